// >>> rtl/pec_pkg.sv
//----------------------------------------------------------------------
// Purpose: Shared constants for the PHY error counter and PCS block
// Assumes: Management register port and logic run on the 40 MHz clk
// Notes: Offsets are the 5-bit management register numbers
//----------------------------------------------------------------------
package pec_pkg;

    //------------------------------------------------------------------
    // Register offsets
    //------------------------------------------------------------------
    localparam logic [4:0] FCC_ADDR = 5'h14; // false_carrier_count
    localparam logic [4:0] REC_ADDR = 5'h15; // receive_error_count
    localparam logic [4:0] PCS_ADDR = 5'h16; // coding_sublayer_config_status

    //------------------------------------------------------------------
    // Control register field positions
    //------------------------------------------------------------------
    localparam int unsigned RXCLK_BIT = 11;
    localparam int unsigned TQ_BIT = 10;
    localparam int unsigned SDF_BIT = 9;
    localparam int unsigned SDP_BIT = 8;
    localparam int unsigned DTS_BIT = 7;
    localparam int unsigned F100_BIT = 5;
    localparam int unsigned NRZI_BIT = 2;

    //------------------------------------------------------------------
    // Reset values and masks
    //------------------------------------------------------------------
    localparam logic [15:0] PCS_RESET = 16'h0100;
    localparam logic [15:0] PCS_WMASK = 16'h0FA4; // Bits 11,10,9,8,7,5,2
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [7:0] CNT_MAX = 8'hFF;
    localparam logic [7:0] CNT_HALF = 8'h80;

    //------------------------------------------------------------------
    // Timing
    //------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned DESC_SHORT_US = 722;
    localparam int unsigned DESC_LONG_MS = 2;
    localparam int unsigned DESC_SHORT_CYC = DESC_SHORT_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned DESC_LONG_CYC = DESC_LONG_MS * 1000000 / CLK_PERIOD_NS;

    //------------------------------------------------------------------
    // Link state
    //------------------------------------------------------------------
    typedef enum logic [1:0] {
        PEC_LINK_DOWN = 2'b01,
        PEC_LINK_UP = 2'b10
    } pec_link_state_t;

endpackage

// >>> rtl/pec_cnt_if.sv
//----------------------------------------------------------------------
// Purpose: Carrier between the top and one saturating counter
// Assumes: All signals on the top's clk
// Notes: half is a one-cycle pulse when the count reaches mid range
//----------------------------------------------------------------------
`timescale 1ns/1ps
interface pec_cnt_if;
    logic evt;
    logic clr;
    logic [7:0] value;
    logic half;
    modport counter (input evt, input clr, output value, output half);
    modport user (output evt, output clr, input value, input half);
endinterface

// >>> rtl/pec_sat_counter.sv
//----------------------------------------------------------------------
// Purpose: 8-bit saturating, clear-on-read event counter
// Assumes: evt and clr are single-cycle strobes on clk
// Notes: An event in the clearing cycle survives as a count of one
//----------------------------------------------------------------------
`timescale 1ns/1ps
module pec_sat_counter (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    pec_cnt_if.counter cnt
);

    //------------------------------------------------------------------
    // Count with saturation and read clear
    //------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cnt.value <= pec_pkg::CNT_RESET[7:0];
        end else if (ce) begin
            if (cnt.clr) begin
                cnt.value <= {7'h00, cnt.evt};
            end else if (cnt.evt && cnt.value != pec_pkg::CNT_MAX) begin
                cnt.value <= cnt.value + 8'h01;
            end
        end
    end

    // Mid-range pulse, only on the step that lands on the half value;
    // held while ce is low so the sticky flag upstream cannot miss it
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cnt.half <= 1'b0;
        end else if (ce) begin
            cnt.half <= cnt.evt && !cnt.clr
                && cnt.value == pec_pkg::CNT_HALF - 8'h01;
        end
    end

endmodule

// >>> rtl/pec_link.sv
//----------------------------------------------------------------------
// Purpose: 100 Mb/s link keeping and descrambler lock timeout
// Assumes: Lock and idle indications come from the PCS on clk
// Notes: Timeouts are parameters so a simulation can shorten them
//----------------------------------------------------------------------
`timescale 1ns/1ps
module pec_link #(
    parameter int unsigned SHORT_CYC = pec_pkg::DESC_SHORT_CYC,
    parameter int unsigned LONG_CYC = pec_pkg::DESC_LONG_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic sd,
    input wire logic lock_raw,
    input wire logic idle_seen,
    input wire logic long_sel,
    input wire logic policy,
    input wire logic force_good,
    output logic sync_ok_q,
    output logic link_q
);
    localparam int unsigned TW = $clog2(LONG_CYC + 1);

    if (SHORT_CYC < 1 || LONG_CYC < SHORT_CYC) begin : g_bad
        $error("pec_link: timeouts must satisfy 1 <= SHORT_CYC <= LONG_CYC");
    end

    logic [TW-1:0] limit;
    logic [TW-1:0] timer_q;
    logic [TW-1:0] timer_d;
    logic sync_d;
    pec_pkg::pec_link_state_t state_q;
    pec_pkg::pec_link_state_t state_d;

    //------------------------------------------------------------------
    // Descrambler timeout
    //------------------------------------------------------------------
    // Idle symbols refresh the timer; a long gap means lost sync
    assign limit = long_sel ? TW'(LONG_CYC) : TW'(SHORT_CYC);
    always_comb begin
        if (!lock_raw || idle_seen) begin
            timer_d = '0;
        end else if (timer_q < limit) begin
            timer_d = timer_q + TW'(1);
        end else begin
            timer_d = timer_q;
        end
        sync_d = lock_raw && (timer_d < limit);
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            timer_q <= '0;
            sync_ok_q <= 1'b0;
        end else if (ce) begin
            timer_q <= timer_d;
            sync_ok_q <= sync_d;
        end
    end

    //------------------------------------------------------------------
    // Link state
    //------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            pec_pkg::PEC_LINK_DOWN: begin
                if (sd && sync_ok_q) begin
                    state_d = pec_pkg::PEC_LINK_UP;
                end
            end
            pec_pkg::PEC_LINK_UP: begin
                if (!sd || (!policy && !sync_ok_q)) begin
                    state_d = pec_pkg::PEC_LINK_DOWN;
                end
            end
            default: state_d = pec_pkg::PEC_LINK_DOWN;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_q <= pec_pkg::PEC_LINK_DOWN;
            link_q <= 1'b0;
        end else if (ce) begin
            state_q <= state_d;
            link_q <= force_good || state_d == pec_pkg::PEC_LINK_UP;
        end
    end

    //------------------------------------------------------------------
    // Checks
    //------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    chk_link_keep_nolock: assert property (
        ce && state_q == pec_pkg::PEC_LINK_UP && sd && policy |=> state_q == pec_pkg::PEC_LINK_UP)
        else $error("link dropped on lock loss with keep policy");
    chk_link_drop_lock: assert property (
        ce && state_q == pec_pkg::PEC_LINK_UP && !policy && !sync_ok_q
        |=> state_q == pec_pkg::PEC_LINK_DOWN)
        else $error("link kept without lock under strict policy");
    chk_desc_timeout: assert property (
        ce && lock_raw && !idle_seen && timer_q == limit - TW'(1) |=> !sync_ok_q)
        else $error("descrambler timeout not taken at limit");
    chk_force_link: assert property (
        ce && force_good |=> link_q)
        else $error("forced good link not reported");

endmodule

// >>> rtl/pec_top.sv
//----------------------------------------------------------------------
// Purpose: Error counters and 100 Mb/s PCS configuration registers
// Assumes: Register strobes and PCS events are synchronous to clk
// Notes: Reads return data one cycle after the read strobe
//----------------------------------------------------------------------
// Function
// - False carrier events increment an 8-bit tally in the low byte.
// - False carrier tally sticks at FFh until a read clears it.
// - Both tallies reset to zero, clear on read, ignore writes.
// - Receive error tally counts carriers holding at least one bad symbol.
// - Receive error tally advances at most once per carrier event.
// - A carrier event with collision never advances the receive error tally.
// - Receive error tally saturates at its maximum instead of wrapping.
// - Counter registers read zero in bits 15:8 and ignore writes.
// - Bit 10 set selects true quiet transmit, clear selects normal.
// - Bit 9 set forces signal detect, clear lets the line decide.
// - Policy bit 8 set: link needs signal and lock, keeps on signal.
// - Policy bit 8 clear: link drops on signal loss or lock loss.
// - Bit 7 picks descrambler timeout: 722 us when clear, 2 ms when set.
// - Bit 5 set reports good 100 Mb/s link whatever the line does.
// - Bit 2 set bypasses NRZI coding in the 100 Mb/s path.
// - Control register bits 15:13 read zero and ignore writes.
// - Each tally reaching half range sets a flag cleared by status read.
//----------------------------------------------------------------------
`timescale 1ns/1ps
module pec_top #(
    parameter int unsigned SHORT_CYC = pec_pkg::DESC_SHORT_CYC,
    parameter int unsigned LONG_CYC = pec_pkg::DESC_LONG_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [4:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    input wire logic isr_rd,
    input wire logic false_carrier,
    input wire logic carrier_valid,
    input wire logic symbol_error,
    input wire logic collision,
    input wire logic signal_level_ok,
    input wire logic descrambler_locked,
    input wire logic idle_seen,
    output logic true_quiet_enable,
    output logic signal_detect_force,
    output logic signal_detect_pma,
    output logic signal_detect_link_policy,
    output logic descrambler_timeout_select,
    output logic force_good_link,
    output logic nrzi_bypass,
    output logic rx_clock_free,
    output logic descrambler_sync_ok,
    output logic link_good_100,
    output logic false_carrier_half_full_flag,
    output logic receive_error_half_full_flag
);

    //------------------------------------------------------------------
    // Helpers
    //------------------------------------------------------------------
    // Address match shared by read, write and clear decoding
    function automatic logic reg_hit(input logic [4:0] a, input logic [4:0] target);
        return a == target;
    endfunction

    pec_cnt_if fc_if ();
    pec_cnt_if rx_if ();

    logic [15:0] pcs_q;
    logic [15:0] rdata_d;
    logic carrier_q;
    logic err_seen_q;
    logic coll_seen_q;
    logic carrier_end;
    logic fc_half_q;
    logic rx_half_q;
    logic sd_pma_q;
    logic sync_ok;
    logic link_ok;

    //------------------------------------------------------------------
    // Control register
    //------------------------------------------------------------------
    // Only implemented bits are stored, so reserved bits cannot leak
    // back on a read even if software breaks the write-zero convention
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pcs_q <= pec_pkg::PCS_RESET;
        end else if (ce && reg_wr && reg_hit(reg_addr, pec_pkg::PCS_ADDR)) begin
            pcs_q <= reg_wdata & pec_pkg::PCS_WMASK;
        end
    end

    // Control bits go straight out of the register
    assign true_quiet_enable = pcs_q[pec_pkg::TQ_BIT];
    assign signal_detect_force = pcs_q[pec_pkg::SDF_BIT];
    assign signal_detect_link_policy = pcs_q[pec_pkg::SDP_BIT];
    assign descrambler_timeout_select = pcs_q[pec_pkg::DTS_BIT];
    assign force_good_link = pcs_q[pec_pkg::F100_BIT];
    assign nrzi_bypass = pcs_q[pec_pkg::NRZI_BIT];
    assign rx_clock_free = pcs_q[pec_pkg::RXCLK_BIT];

    // Signal detect towards the attachment logic, forced or from the line
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sd_pma_q <= 1'b0;
        end else if (ce) begin
            sd_pma_q <= pcs_q[pec_pkg::SDF_BIT] | signal_level_ok;
        end
    end
    assign signal_detect_pma = sd_pma_q;

    //------------------------------------------------------------------
    // False carrier tally
    //------------------------------------------------------------------
    assign fc_if.evt = false_carrier;
    assign fc_if.clr = reg_rd && reg_hit(reg_addr, pec_pkg::FCC_ADDR);

    pec_sat_counter u_fc_cnt (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .cnt(fc_if)
    );

    //------------------------------------------------------------------
    // Receive error carrier tracking
    //------------------------------------------------------------------
    // Errors and collisions are remembered over a whole carrier and
    // judged once at its end, so many bad symbols still count once
    assign carrier_end = carrier_q && !carrier_valid;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            carrier_q <= 1'b0;
            err_seen_q <= 1'b0;
            coll_seen_q <= 1'b0;
        end else if (ce) begin
            carrier_q <= carrier_valid;
            if (carrier_valid) begin
                err_seen_q <= err_seen_q | symbol_error;
                coll_seen_q <= coll_seen_q | collision;
            end else begin
                err_seen_q <= 1'b0;
                coll_seen_q <= 1'b0;
            end
        end
    end

    assign rx_if.evt = carrier_end && err_seen_q && !coll_seen_q;
    assign rx_if.clr = reg_rd && reg_hit(reg_addr, pec_pkg::REC_ADDR);

    pec_sat_counter u_rx_cnt (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .cnt(rx_if)
    );

    //------------------------------------------------------------------
    // Half-full flags
    //------------------------------------------------------------------
    // A new half-full step beats a same-cycle status read
    always_ff @(posedge clk) begin
        if (!rstn) begin
            fc_half_q <= 1'b0;
            rx_half_q <= 1'b0;
        end else if (ce) begin
            fc_half_q <= fc_if.half | (fc_half_q & ~isr_rd);
            rx_half_q <= rx_if.half | (rx_half_q & ~isr_rd);
        end
    end
    assign false_carrier_half_full_flag = fc_half_q;
    assign receive_error_half_full_flag = rx_half_q;

    //------------------------------------------------------------------
    // Link keeping
    //------------------------------------------------------------------
    pec_link #(
        .SHORT_CYC(SHORT_CYC),
        .LONG_CYC(LONG_CYC)
    ) u_link (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .sd(pcs_q[pec_pkg::SDF_BIT] | signal_level_ok),
        .lock_raw(descrambler_locked),
        .idle_seen(idle_seen),
        .long_sel(pcs_q[pec_pkg::DTS_BIT]),
        .policy(pcs_q[pec_pkg::SDP_BIT]),
        .force_good(pcs_q[pec_pkg::F100_BIT]),
        .sync_ok_q(sync_ok),
        .link_q(link_ok)
    );
    assign descrambler_sync_ok = sync_ok;
    assign link_good_100 = link_ok;

    //------------------------------------------------------------------
    // Read data
    //------------------------------------------------------------------
    // Unmapped offsets read zero; the read register holds until next read
    always_comb begin
        rdata_d = 16'h0000;
        if (reg_hit(reg_addr, pec_pkg::FCC_ADDR)) begin
            rdata_d = {8'h00, fc_if.value};
        end else if (reg_hit(reg_addr, pec_pkg::REC_ADDR)) begin
            rdata_d = {8'h00, rx_if.value};
        end else if (reg_hit(reg_addr, pec_pkg::PCS_ADDR)) begin
            rdata_d = pcs_q & pec_pkg::PCS_WMASK;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            reg_rdata <= 16'h0000;
        end else if (ce && reg_rd) begin
            reg_rdata <= rdata_d;
        end
    end

    //------------------------------------------------------------------
    // Checks
    //------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_fc_step;
        ce && fc_if.evt && !fc_if.clr && fc_if.value != pec_pkg::CNT_MAX;
    endsequence

    sequence s_carrier_bad;
        ce && carrier_valid && symbol_error && !collision;
    endsequence

    chk_fc_increment: assert property (
        s_fc_step |=> fc_if.value == $past(fc_if.value) + 8'h01)
        else $error("false carrier tally did not step");
    chk_fc_saturate: assert property (
        ce && !fc_if.clr && fc_if.value == pec_pkg::CNT_MAX |=> fc_if.value == pec_pkg::CNT_MAX)
        else $error("false carrier tally wrapped");
    chk_read_clears: assert property (
        ce && reg_rd && reg_hit(reg_addr, pec_pkg::REC_ADDR) && !rx_if.evt
        |=> rx_if.value == 8'h00)
        else $error("receive error tally not cleared by read");
    chk_write_ignored: assert property (
        ce && reg_wr && !reg_rd && !false_carrier && reg_hit(reg_addr, pec_pkg::FCC_ADDR)
        |=> $stable(fc_if.value))
        else $error("write altered false carrier tally");
    chk_rx_bad_carrier: assert property (
        s_carrier_bad ##1 (ce && !carrier_valid && !collision && !reg_rd
            && !coll_seen_q && rx_if.value != pec_pkg::CNT_MAX)
        |=> rx_if.value == $past(rx_if.value) + 8'h01)
        else $error("bad carrier not counted");
    chk_rx_once: assert property (
        ce && carrier_valid && carrier_q |=> rx_if.value <= $past(rx_if.value))
        else $error("receive error tally moved during carrier");
    chk_rx_collision: assert property (
        ce && carrier_end && coll_seen_q && !reg_rd |=> $stable(rx_if.value))
        else $error("collision carrier counted");
    chk_rx_saturate: assert property (
        ce && !rx_if.clr && rx_if.value == pec_pkg::CNT_MAX |=> rx_if.value == pec_pkg::CNT_MAX)
        else $error("receive error tally wrapped");
    chk_cnt_upper_zero: assert property (
        ce && reg_rd && (reg_hit(reg_addr, pec_pkg::FCC_ADDR)
            || reg_hit(reg_addr, pec_pkg::REC_ADDR))
        |=> reg_rdata[15:8] == 8'h00 && reg_rdata[7:0] == $past(rdata_d[7:0]))
        else $error("counter read upper byte not zero");
    chk_tq_follow: assert property (
        ce && reg_wr && reg_hit(reg_addr, pec_pkg::PCS_ADDR)
        |=> true_quiet_enable == $past(reg_wdata[pec_pkg::TQ_BIT]))
        else $error("true quiet enable not taken from write");
    chk_sd_force: assert property (
        ce && signal_detect_force |=> signal_detect_pma)
        else $error("forced signal detect not driven");
    chk_nrzi_follow: assert property (
        ce && reg_wr && reg_hit(reg_addr, pec_pkg::PCS_ADDR)
        |=> nrzi_bypass == $past(reg_wdata[pec_pkg::NRZI_BIT]))
        else $error("nrzi bypass not taken from write");
    chk_pcs_upper_zero: assert property (
        ce && reg_rd && reg_hit(reg_addr, pec_pkg::PCS_ADDR) |=> reg_rdata[15:12] == 4'h0)
        else $error("control register reserved bits not zero");
    chk_half_flag: assert property (
        ce && fc_if.evt && !fc_if.clr && fc_if.value == pec_pkg::CNT_HALF - 8'h01
        ##1 ce |=> false_carrier_half_full_flag)
        else $error("half full flag not set");
    chk_clear_race: assert property (
        ce && fc_if.clr && fc_if.evt |=> fc_if.value == 8'h01)
        else $error("event lost in clearing read");
    chk_rxclk_rw: assert property (
        ce && reg_wr && reg_hit(reg_addr, pec_pkg::PCS_ADDR)
        |=> rx_clock_free == $past(reg_wdata[pec_pkg::RXCLK_BIT]))
        else $error("receive clock bit not stored");

endmodule

// >>> bench/pec_sta_mgr.sv
//----------------------------------------------------------------------
// Purpose: Station manager model on the register strobe port
// Assumes: Strobes change on the falling edge of clk
// Notes: Released write data is inverted so stale values never pass
//----------------------------------------------------------------------
`timescale 1ns/1ps
module pec_sta_mgr (
    input wire logic clk,
    output logic [4:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata
);
    // Idle bus at time zero
    initial begin
        {reg_addr, reg_wr, reg_rd, reg_wdata} = '0;
    end
    // One strobe, answer taken one edge later
    task automatic xfer(input logic [4:0] a, input logic w, input logic [15:0] d,
                        output logic [15:0] q);
        @(negedge clk);
        reg_addr = a;
        reg_wr = w;
        reg_rd = !w;
        reg_wdata = (a == pec_pkg::PCS_ADDR) ? (d & 16'hEFA4) : d;
        @(negedge clk);
        q = reg_rdata;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = ~reg_wdata;
    endtask
endmodule

// >>> bench/testbench.sv
//----------------------------------------------------------------------
// Purpose: Self-checking bench for the counters and control register
// Assumes: Timeouts shortened to 20 and 50 cycles
// Notes: Integer model of both tallies and the control word
//----------------------------------------------------------------------
`timescale 1ns/1ps
`define CHK(s, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
    $display("MISMATCH %s exp %h got %h", s, e, g); end end
module testbench;
    logic clk = 0, rstn = 0, isr_rd = 0, fcar = 0, cv = 0, serr = 0, col = 0;
    logic sl = 0, lk = 0, idl = 0;
    logic [4:0] addr;
    logic wr, rd;
    logic [15:0] wdata, rdata;
    logic [15:0] pcs = 16'h0100;
    wire [15:0] o;
    int bad_count = 0, n_compared = 0, cyc = 0, fc = 0, re = 0, n;
    // Clock and hang guard
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            print_verdict();
        end
    end
    pec_sta_mgr mgr (.clk(clk), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd),
        .reg_wdata(wdata), .reg_rdata(rdata));
    pec_top #(.SHORT_CYC(20), .LONG_CYC(50)) dut (.clk(clk), .rstn(rstn), .ce(1'b1),
        .reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata), .reg_rdata(rdata),
        .isr_rd(isr_rd), .false_carrier(fcar), .carrier_valid(cv), .symbol_error(serr),
        .collision(col), .signal_level_ok(sl), .descrambler_locked(lk),
        .idle_seen(idl), .true_quiet_enable(o[10]), .signal_detect_force(o[9]),
        .signal_detect_pma(o[12]), .signal_detect_link_policy(o[8]),
        .descrambler_timeout_select(o[7]), .force_good_link(o[5]), .nrzi_bypass(o[2]),
        .rx_clock_free(o[11]), .descrambler_sync_ok(o[13]), .link_good_100(o[0]),
        .false_carrier_half_full_flag(o[15]), .receive_error_half_full_flag(o[14]));
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic rdc(input logic [4:0] a, input logic [15:0] e);
        logic [15:0] q;
        mgr.xfer(a, 1'b0, 16'h0000, q);
        `CHK("rdata", e, q)
    endtask
    task automatic wrc(input logic [4:0] a, input logic [15:0] d);
        logic [15:0] q;
        mgr.xfer(a, 1'b1, d, q);
        if (a == 5'h16) pcs = d & 16'h0FA4;
    endtask
    // Held strobe gives k back-to-back false carriers
    task automatic fcp(input int k);
        @(negedge clk);
        fcar = 1'b1;
        repeat (k) @(negedge clk);
        fcar = 1'b0;
        fc = (fc + k > 255) ? 255 : fc + k;
    endtask
    // One carrier of ne+2 cycles, symbol error held throughout if ne > 0; judged when carrier ends
    task automatic car(input int ne, input logic c);
        @(negedge clk);
        {cv, col} = {1'b1, c};
        serr = (ne > 0);
        repeat (ne + 2) @(negedge clk);
        {cv, col, serr} = 3'b000;
        repeat (3) @(negedge clk);
        if (ne > 0 && !c && re < 255) re++;
    endtask
    initial begin
        void'($urandom(32'hEECB0911));
        repeat (20) @(negedge clk);
        rstn = 1'b1;
        rdc(5'h16, pcs);
        rdc(5'h14, 16'h0000);
        `CHK("ctl", pcs, o & 16'h0FA4)
        // All ones first, then random words
        for (n = 0; n < 4; n++) begin
            wrc(5'h16, n == 0 ? 16'hFFFF : 16'($urandom));
            rdc(5'h16, pcs);
            `CHK("ctl", pcs, o & 16'h0FA4)
            `CHK("link", pcs[5], o[0])
        end
        $display("control test done");
        wrc(5'h14, 16'hFFFF);
        fcp($urandom_range(1, 9));
        rdc(5'h14, 16'(fc));
        fc = 0;
        rdc(5'h14, 16'h0000);
        fcp(300);
        `CHK("fhf", 1'b1, o[15])
        rdc(5'h14, 16'(fc));
        fc = 0;
        @(negedge clk) isr_rd = 1'b1;
        @(negedge clk) isr_rd = 1'b0;
        `CHK("fhf", 1'b0, o[15])
        fork
            rdc(5'h14, 16'h0000);
            fcp(1);
        join
        rdc(5'h14, 16'(fc));
        $display("false carrier test done");
        car(3, 1'b0);
        car(2, 1'b1);
        car(0, 1'b0);
        rdc(5'h15, 16'(re));
        re = 0;
        repeat (260) car(1, 1'b0);
        rdc(5'h15, 16'(re));
        `CHK("rhf", 1'b1, o[14])
        wrc(5'h15, 16'hFFFF);
        rdc(5'h15, 16'h0000);
        $display("receive error test done");
        // Strict policy, short timeout: lock held without idles runs out
        wrc(5'h16, 16'h0000);
        @(negedge clk) {sl, lk} = 2'b11;
        repeat (3) @(negedge clk);
        `CHK("sync", 1'b1, o[13])
        `CHK("link", 1'b1, o[0])
        `CHK("pma", 1'b1, o[12])
        repeat (25) @(negedge clk);
        `CHK("sync", 1'b0, o[13])
        `CHK("link", 1'b0, o[0])
        // Keep policy, long timeout: link outlives lock, not the signal
        wrc(5'h16, 16'h0180);
        @(negedge clk) idl = 1'b1;
        @(negedge clk) idl = 1'b0;
        repeat (28) @(negedge clk);
        `CHK("sync", 1'b1, o[13])
        `CHK("link", 1'b1, o[0])
        repeat (30) @(negedge clk);
        `CHK("sync", 1'b0, o[13])
        `CHK("link", 1'b1, o[0])
        sl = 1'b0;
        repeat (2) @(negedge clk);
        `CHK("link", 1'b0, o[0])
        `CHK("pma", 1'b0, o[12])
        wrc(5'h16, 16'h0200);
        @(negedge clk);
        `CHK("pma", 1'b1, o[12])
        $display("link test done");
        print_verdict();
    end
endmodule
